/* bench/mgmt_station_model.sv */
`timescale 1ns/1ps
module mgmt_station_model (
    input  wire         clk,
    input  wire  [15:0] regRdData,
    input  wire         regRdValid,
    output logic [4:0]  regAddr = 5'h00,
    output logic        regWrEn = 1'b0,
    output logic        regRdEn = 1'b0,
    output logic [15:0] regWrData = 16'h0000
);
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == 5'h1F) v[11:5] = 7'h02;
        if (a == 5'h1B && v[15:13] == 3'b111) v[13] = 1'b0;
        @(negedge clk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    // Answer is registered, so it is taken one cycle after the request
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        d = regRdData;
        ok = regRdValid;
    endtask
endmodule // mgmt_station_model

/* bench/phy_crossover_irq_properties.sv */
`timescale 1ns/1ps
module phy_crossover_irq_checker (
    input wire        clk, rst, softReset, regWrEn, regRdEn, regRdValid,
    input wire [4:0]  regAddr,
    input wire [15:0] regWrData, regRdData,
    input wire        polarityReversed, negotiationDone, remoteFault,
    input wire [2:0]  resolvedSpeedDuplex,
    input wire        autoCrossoverActive, pairSwap, rxPllReferenceLock
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Soft reset excluded: it would clear the control bits being written
    wire xoWr = regWrEn && regAddr == 5'h1B && !softReset;
    wire rdMapped = regAddr == 5'h1B || regAddr == 5'h1D || regAddr == 5'h1E || regAddr == 5'h1F;
    a_read_valid_pulse: assert property (regRdEn |=> regRdValid) else $error("read valid missing");
    a_no_stray_valid: assert property (!regRdEn |=> !regRdValid) else $error("read valid without read");
    a_pll_lock_write: assert property (xoWr |-> ##2 rxPllReferenceLock == $past(regWrData[10], 2))
        else $error("pll lock not following write");
    a_manual_pair_swap: assert property (xoWr && regWrData[15:14] == 2'b10
        |-> ##2 (pairSwap == $past(regWrData[13], 2)) && !autoCrossoverActive) else $error("manual swap wrong");
    a_override_auto_on: assert property (xoWr && regWrData[15:14] == 2'b11 |-> ##2 autoCrossoverActive)
        else $error("auto crossover not enabled");
    a_strap_mode_swap: assert property (xoWr && !regWrData[15] |-> ##2 (!pairSwap || autoCrossoverActive))
        else $error("state bit used without override");
    a_polarity_read_back: assert property (regRdEn && regAddr == 5'h1B
        |=> regRdData[4] == $past(polarityReversed)) else $error("polarity bit wrong");
    a_link_result_read: assert property (regRdEn && regAddr == 5'h1F
        |=> regRdData[12] == $past(negotiationDone) && regRdData[4:2] == $past(resolvedSpeedDuplex))
        else $error("link result wrong");
    a_unmapped_read_zero: assert property (regRdEn && !rdMapped |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_flag_high_bits: assert property (regRdEn && regAddr == 5'h1D
        |=> regRdData[15:8] == 8'h00 && !regRdData[0]) else $error("reserved flag bits set");
    a_remote_flag_latch: assert property (remoteFault ##1 (regRdEn && regAddr == 5'h1D) |=> regRdData[5])
        else $error("remote fault flag lost");
endmodule // phy_crossover_irq_checker
bind phy_crossover_irq_status_regs phy_crossover_irq_checker chk (.clk(clk), .rst(rst), .softReset(softReset),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdValid(regRdValid), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .polarityReversed(polarityReversed), .negotiationDone(negotiationDone),
    .remoteFault(remoteFault), .resolvedSpeedDuplex(resolvedSpeedDuplex),
    .autoCrossoverActive(autoCrossoverActive), .pairSwap(pairSwap), .rxPllReferenceLock(rxPllReferenceLock));

/* bench/phy_crossover_irq_status_regs_tb_top.sv */
`timescale 1ns/1ps
module phy_crossover_irq_status_regs_tb_top;
    logic clk = 1'b0, rst = 1'b1, softReset = 1'b0, swap = 1'b1, pol = 1'b0, energy = 1'b1, strap = 1'b1;
    logic negDone = 1'b0, linkUp = 1'b1, regWrEn, regRdEn, regRdValid, ok;
    logic [3:0] ev = 4'h0;
    logic [2:0] speed = 3'h5;
    logic [4:0] regAddr;
    logic [15:0] regWrData, regRdData, d;
    logic autoCrossoverActive, pairSwap, rxPllReferenceLock, phyIrq;
    logic [15:0] flagBit [4] = '{16'h0002, 16'h0004, 16'h0008, 16'h0020};
    logic [15:0] xoData [4] = '{16'hA000, 16'h8000, 16'hC000, 16'hE000};
    logic [1:0] xoExp [4] = '{2'b01, 2'b00, 2'b11, 2'b11};
    logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
    int n_fail = 0, tests_run = 0;
    // Short quiet period keeps the energy timeout within a few cycles
    phy_crossover_irq_status_regs #(.QUIET_CYCLES(24'd20)) uut (.clk(clk), .rst(rst), .softReset(softReset),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .autoCrossoverStrap(strap), .autoCrossoverSwap(swap), .polarityReversed(pol),
        .lineEnergyValid(energy), .negotiationDone(negDone), .remoteFault(ev[3]), .linkUp(linkUp),
        .partnerAck(ev[2]), .parallelDetectFault(ev[1]), .pageReceived(ev[0]), .resolvedSpeedDuplex(speed),
        .autoCrossoverActive(autoCrossoverActive), .pairSwap(pairSwap), .rxPllReferenceLock(rxPllReferenceLock),
        .phyIrq(phyIrq));
    mgmt_station_model m (.clk(clk), .regRdData(regRdData), .regRdValid(regRdValid), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
        m.rd(a, d, ok);
        chk("read valid", {15'h0000, ok}, 16'h0001);
        chk("read data", d, exp);
    endtask
    task automatic final_report;
        $display("Checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        n_fail++;
        final_report;
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("strap auto", {15'h0000, autoCrossoverActive}, 16'h0001);
        rdChk(5'h1B, 16'h0000);
        rdChk(5'h1D, 16'h0000);
        rdChk(5'h1E, 16'h0000);
        rdChk(5'h00, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            m.wr(5'h1B, xoData[i]);
            @(negedge clk);
            chk("crossover", {14'h0000, autoCrossoverActive, pairSwap}, {14'h0000, xoExp[i]});
        end
        rdChk(5'h1B, 16'hC000);
        m.wr(5'h1B, 16'h0400);
        @(negedge clk);
        chk("pll lock", {14'h0000, rxPllReferenceLock, autoCrossoverActive}, 16'h0003);
        m.wr(5'h1E, 16'h00FE);
        rdChk(5'h1E, 16'h00FE);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) ev = 4'h1 << i;
            @(negedge clk) ev = 4'h0;
            @(negedge clk);
            chk("irq raised", {15'h0000, phyIrq}, 16'h0001);
            rdChk(5'h1D, flagBit[i]);
            rdChk(5'h1D, 16'h0000);
        end
        chk("irq cleared", {15'h0000, phyIrq}, 16'h0000);
        @(negedge clk) linkUp = 1'b0;
        rdChk(5'h1D, 16'h0010);
        energy = 1'b0;
        repeat (30) @(negedge clk);
        energy = 1'b1;
        @(negedge clk) negDone = 1'b1;
        rdChk(5'h1D, 16'h00C0);
        for (int i = 0; i < 4; i++) begin
            speed = codes[i];
            rdChk(5'h1F, {3'h0, 1'b1, 7'h02, codes[i], 2'h0});
        end
        m.wr(5'h1E, 16'h0000);
        @(negedge clk) ev = 4'h8;
        @(negedge clk) ev = 4'h0;
        @(negedge clk);
        chk("irq masked", {15'h0000, phyIrq}, 16'h0000);
        m.wr(5'h1D, 16'hFFFF);
        rdChk(5'h1D, 16'h0020);
        rdChk(5'h1D, 16'h0000);
        m.wr(5'h1E, 16'h00FE);
        @(negedge clk) softReset = 1'b1;
        @(negedge clk) softReset = 1'b0;
        rdChk(5'h1E, 16'h0000);
        rdChk(5'h1F, {3'h0, 1'b1, 7'h02, 3'h6, 2'h0});
        chk("soft reset pll", {15'h0000, rxPllReferenceLock}, 16'h0000);
        // Second reset with the strap low; state bit must not act without override
        @(negedge clk) strap = 1'b0;
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        pol = 1'b1;
        repeat (4) @(negedge clk);
        chk("strap off", {14'h0000, autoCrossoverActive, pairSwap}, 16'h0000);
        m.wr(5'h1B, 16'h2000);
        @(negedge clk);
        chk("state ignored", {14'h0000, autoCrossoverActive, pairSwap}, 16'h0000);
        rdChk(5'h1B, 16'h2010);
        m.wr(5'h1B, 16'hC000);
        @(negedge clk);
        chk("override auto", {14'h0000, autoCrossoverActive, pairSwap}, 16'h0003);
        final_report;
    end
endmodule // phy_crossover_irq_status_regs_tb_top

/* rtl/phy_crossover_irq_regs.vh */
`ifndef PHY_CROSSOVER_IRQ_REGS_VH
`define PHY_CROSSOVER_IRQ_REGS_VH

// Register indices on the management port
`define ADDR_CROSSOVER      5'h1B
`define ADDR_IRQ_FLAGS      5'h1D
`define ADDR_IRQ_MASK       5'h1E
`define ADDR_LINK_RESULT    5'h1F

// Crossover control/status fields
`define XO_OVERRIDE_BIT     15
`define XO_AUTO_EN_BIT      14
`define XO_STATE_BIT        13
`define XO_PLL_LOCK_BIT     10
`define XO_POLARITY_BIT     4

// Interrupt flag and mask fields
`define IRQ_MSB             7
`define IRQ_LSB             1
`define IRQ_ENERGY_BIT      7
`define IRQ_NEG_DONE_BIT    6
`define IRQ_REMOTE_BIT      5
`define IRQ_LINK_DOWN_BIT   4
`define IRQ_ACK_BIT         3
`define IRQ_PARFAULT_BIT    2
`define IRQ_PAGE_BIT        1
`define IRQ_MASK_RESET      8'h00

// Link result fields
`define LR_DONE_BIT         12
`define LR_RSVD_MSB         11
`define LR_RSVD_LSB         5
`define LR_RSVD_RESET       7'h02
`define LR_SPEED_MSB        4
`define LR_SPEED_LSB        2

// Speed/duplex codes
`define SPD_10_HALF         3'h1
`define SPD_10_FULL         3'h5
`define SPD_100_HALF        3'h2
`define SPD_100_FULL        3'h6

// Timing
`define CLK_HZ              40000000
`define ENERGY_QUIET_MS     256
`define STRAP_SETTLE        2'h3
// 256 ms of 40 MHz cycles, sized to the quiet counter
`define ENERGY_QUIET_CYCLES 24'h9C4000

`endif

/* rtl/phy_crossover_irq_status_regs.v */
`timescale 1ns/1ps
`include "phy_crossover_irq_regs.vh"

module phy_crossover_irq_status_regs #(
    parameter [23:0] QUIET_CYCLES = `ENERGY_QUIET_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    input  wire        softReset,
    // Management register port
    input  wire [4:0]  regAddr,
    input  wire        regWrEn,
    input  wire [15:0] regWrData,
    input  wire        regRdEn,
    output reg  [15:0] regRdData,
    output reg         regRdValid,
    // Configuration strap pin
    input  wire        autoCrossoverStrap,
    // Status from PHY logic
    input  wire        autoCrossoverSwap,
    input  wire        polarityReversed,
    input  wire        lineEnergyValid,
    input  wire        negotiationDone,
    input  wire        remoteFault,
    input  wire        linkUp,
    input  wire        partnerAck,
    input  wire        parallelDetectFault,
    input  wire        pageReceived,
    input  wire [2:0]  resolvedSpeedDuplex,
    // Controls to PHY logic
    output reg         autoCrossoverActive,
    output reg         pairSwap,
    output reg         rxPllReferenceLock,
    output reg         phyIrq
);

    // Strap synchroniser and capture
    reg        strapMeta_r;
    reg        strapSync_r;
    reg [1:0]  strapSettle_r;
    reg        strapLatched_r;

    // Control registers
    reg        overrideStrap_r;
    reg        crossoverEnable_r;
    reg        crossoverState_r;
    reg        pllLock_r;
    reg [6:0]  reservedField_r;

    // Interrupt flags and mask
    reg [7:1]  irqMask_r;
    reg [7:1]  irqFlags_r;
    reg [7:1]  irqFlags_nxt;
    reg [7:1]  irqEvents;

    // Energy detect state and edge history
    reg        lineEnergyDetected_r;
    reg [23:0] quietCount_r;
    reg        energyPrev_r;
    reg        negDonePrev_r;
    reg        linkUpPrev_r;

    // Next values of registered outputs
    reg        autoCrossoverActive_nxt;
    reg        pairSwap_nxt;
    reg [15:0] regRdData_nxt;

    // One-hot register selects
    localparam [3:0] SEL_CROSSOVER = 4'h1;
    localparam [3:0] SEL_FLAGS     = 4'h2;
    localparam [3:0] SEL_MASK      = 4'h4;
    localparam [3:0] SEL_LINK      = 4'h8;

    // Shared by the read path and clear-on-read, so both agree on the map
    function [3:0] regSelect;
        input [4:0] addr;
        begin
            case (addr)
                `ADDR_CROSSOVER:   regSelect = SEL_CROSSOVER;
                `ADDR_IRQ_FLAGS:   regSelect = SEL_FLAGS;
                `ADDR_IRQ_MASK:    regSelect = SEL_MASK;
                `ADDR_LINK_RESULT: regSelect = SEL_LINK;
                default:           regSelect = 4'h0;
            endcase
        end
    endfunction

    // Flags and mask share one layout; bit 0 and the upper byte read 0
    function [15:0] eventWord;
        input [7:1] bits;
        begin
            eventWord = {8'h00, bits, 1'b0};
        end
    endfunction

    // Edge of a level source against its registered copy
    function edgeSeen;
        input level;
        input levelPrev;
        begin
            edgeSeen = level && !levelPrev;
        end
    endfunction

    wire [3:0] rdSel         = regRdEn ? regSelect(regAddr) : 4'h0;
    wire       flagRead      = (rdSel == SEL_FLAGS);
    wire [7:0] maskResetWord = `IRQ_MASK_RESET;
    wire       quietDone     = (quietCount_r >= QUIET_CYCLES - 24'h000001);
    wire       energyRise    = edgeSeen(lineEnergyDetected_r, energyPrev_r);
    wire       negDoneRise   = edgeSeen(negotiationDone, negDonePrev_r);
    wire       linkFall      = edgeSeen(linkUpPrev_r, linkUp);
    wire       irqPending    = |(irqFlags_nxt & irqMask_r);

    // Two-flop synchroniser for the asynchronous strap pin
    always @(posedge clk) begin
        strapMeta_r <= autoCrossoverStrap;
        strapSync_r <= strapMeta_r;
    end

    // Strap caught only once the synchroniser has settled after reset
    always @(posedge clk) begin
        if (rst) begin
            strapSettle_r  <= 2'h0;
            strapLatched_r <= 1'b0;
        end else if (strapSettle_r != `STRAP_SETTLE) begin
            strapSettle_r <= strapSettle_r + 2'h1;
            if (strapSettle_r == (`STRAP_SETTLE - 2'h1))
                strapLatched_r <= strapSync_r;
        end
    end

    // Software-visible control, soft reset restores defaults
    always @(posedge clk) begin
        if (rst || softReset) begin
            overrideStrap_r   <= 1'b0;
            crossoverEnable_r <= 1'b0;
            crossoverState_r  <= 1'b0;
            pllLock_r         <= 1'b0;
            reservedField_r   <= `LR_RSVD_RESET;
            irqMask_r         <= maskResetWord[`IRQ_MSB:`IRQ_LSB];
        end else if (regWrEn) begin
            case (regAddr)
                `ADDR_CROSSOVER: begin
                    overrideStrap_r   <= regWrData[`XO_OVERRIDE_BIT];
                    crossoverEnable_r <= regWrData[`XO_AUTO_EN_BIT];
                    crossoverState_r  <= regWrData[`XO_STATE_BIT];
                    pllLock_r         <= regWrData[`XO_PLL_LOCK_BIT];
                end
                `ADDR_IRQ_MASK:
                    irqMask_r <= regWrData[`IRQ_MSB:`IRQ_LSB];
                `ADDR_LINK_RESULT:
                    reservedField_r <= regWrData[`LR_RSVD_MSB:`LR_RSVD_LSB];
                default: ;
            endcase
        end
    end

    // Crossover mode; enable and state bits count only under override
    always @* begin
        autoCrossoverActive_nxt = 1'b0;
        pairSwap_nxt            = 1'b0;
        case ({overrideStrap_r, crossoverEnable_r})
            2'b10: begin
                autoCrossoverActive_nxt = 1'b0;
                pairSwap_nxt            = crossoverState_r;
            end
            2'b11: begin
                // State bit ignored here; the swap follows autoCrossoverSwap
                autoCrossoverActive_nxt = 1'b1;
                pairSwap_nxt            = autoCrossoverSwap;
            end
            default: begin
                // Without override the captured strap decides
                autoCrossoverActive_nxt = strapLatched_r;
                pairSwap_nxt            = strapLatched_r && autoCrossoverSwap;
            end
        endcase
    end

    // Crossover and PLL controls
    always @(posedge clk) begin
        if (rst) begin
            autoCrossoverActive <= 1'b0;
            pairSwap            <= 1'b0;
            rxPllReferenceLock  <= 1'b0;
        end else begin
            autoCrossoverActive <= autoCrossoverActive_nxt;
            pairSwap            <= pairSwap_nxt;
            rxPllReferenceLock  <= pllLock_r;
        end
    end

    // Energy detect survives soft reset; quiet timer is a parameter for sim
    always @(posedge clk) begin
        if (rst) begin
            lineEnergyDetected_r <= 1'b1;
            quietCount_r         <= 24'h000000;
        end else if (lineEnergyValid) begin
            lineEnergyDetected_r <= 1'b1;
            quietCount_r         <= 24'h000000;
        end else if (quietDone) begin
            lineEnergyDetected_r <= 1'b0;
        end else begin
            quietCount_r <= quietCount_r + 24'h000001;
        end
    end

    // Edge history for level-type sources
    always @(posedge clk) begin
        if (rst) begin
            energyPrev_r  <= 1'b1;
            negDonePrev_r <= 1'b0;
            linkUpPrev_r  <= 1'b0;
        end else begin
            energyPrev_r  <= lineEnergyDetected_r;
            negDonePrev_r <= negotiationDone;
            linkUpPrev_r  <= linkUp;
        end
    end

    always @* begin
        irqEvents = 7'h00;
        irqEvents[`IRQ_ENERGY_BIT]    = energyRise;
        irqEvents[`IRQ_NEG_DONE_BIT]  = negDoneRise;
        irqEvents[`IRQ_REMOTE_BIT]    = remoteFault;
        irqEvents[`IRQ_LINK_DOWN_BIT] = linkFall;
        irqEvents[`IRQ_ACK_BIT]       = partnerAck;
        irqEvents[`IRQ_PARFAULT_BIT]  = parallelDetectFault;
        irqEvents[`IRQ_PAGE_BIT]      = pageReceived;
        // Set beats clear so an event during the read is not lost
        irqFlags_nxt = (flagRead ? 7'h00 : irqFlags_r) | irqEvents;
    end

    // Latched flags
    always @(posedge clk) begin
        if (rst)
            irqFlags_r <= 7'h00;
        else
            irqFlags_r <= irqFlags_nxt;
    end

    // Taken from the next flags so the output rises on the setting edge
    always @(posedge clk) begin
        if (rst)
            phyIrq <= 1'b0;
        else
            phyIrq <= irqPending;
    end

    // Read word assembled ahead of the output flop
    always @* begin
        regRdData_nxt = 16'h0000;
        case (rdSel)
            SEL_CROSSOVER: begin
                regRdData_nxt[`XO_OVERRIDE_BIT] = overrideStrap_r;
                regRdData_nxt[`XO_AUTO_EN_BIT]  = crossoverEnable_r;
                regRdData_nxt[`XO_STATE_BIT]    = crossoverState_r;
                regRdData_nxt[`XO_PLL_LOCK_BIT] = pllLock_r;
                regRdData_nxt[`XO_POLARITY_BIT] = polarityReversed;
            end
            SEL_FLAGS:
                regRdData_nxt = eventWord(irqFlags_r);
            SEL_MASK:
                regRdData_nxt = eventWord(irqMask_r);
            SEL_LINK: begin
                regRdData_nxt[`LR_DONE_BIT]                = negotiationDone;
                regRdData_nxt[`LR_RSVD_MSB:`LR_RSVD_LSB]   = reservedField_r;
                regRdData_nxt[`LR_SPEED_MSB:`LR_SPEED_LSB] = resolvedSpeedDuplex;
            end
            default:
                regRdData_nxt = 16'h0000;
        endcase
    end

    // Data holds until the next read; unmapped indices read zero
    always @(posedge clk) begin
        if (rst) begin
            regRdData  <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn)
                regRdData <= regRdData_nxt;
        end
    end

endmodule // phy_crossover_irq_status_regs
